// File: design/gpe_params.svh
// gpe_params.svh: register offsets, reset values and timing counts for one
// 32-pin gpio port with interrupt, event and lock logic.
// assumes inclusion by bare name from the package and the port module.
`ifndef GPE_PARAMS_SVH
`define GPE_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses); +4 set, +8 clear, +C toggle
// ----------------------------------------------------------------
`define GPE_OFF_OWNER 10'h000
`define GPE_OFF_DRIVE 10'h040
`define GPE_OFF_OUTVAL 10'h050
`define GPE_OFF_LEVEL 10'h060
`define GPE_OFF_IRQEN 10'h090
`define GPE_OFF_MODE_LO 10'h0A0
`define GPE_OFF_MODE_HI 10'h0B0
`define GPE_OFF_GLITCH 10'h0C0
`define GPE_OFF_FLAG 10'h0D0
`define GPE_OFF_EVEN 10'h110
`define GPE_OFF_LOCK 10'h1A0
`define GPE_OFF_UNLOCK 10'h1E0
`define GPE_OFF_ASR 10'h1E4

// ----------------------------------------------------------------
// access kinds, key, reset values
// ----------------------------------------------------------------
`define GPE_ACC_DIRECT 2'h0
`define GPE_ACC_SET 2'h1
`define GPE_ACC_CLEAR 2'h2
`define GPE_ACC_TOGGLE 2'h3
`define GPE_UNLOCK_KEY 8'hAA
`define GPE_KEY_LSB 24
`define GPE_OFS_W 10
`define GPE_RST_WORD 32'h0000_0000
`define GPE_RST_OWNER 32'hFFFF_FFFF
`define GPE_PIN_MASK 32'hFFFF_FFFF
`define GPE_FILT_LAT 2
`endif

// File: design/gpe_pkg.sv
// gpe_pkg.sv: types shared by the gpio port interrupt/event block.
// assumes gpe_params.svh on the include path.
`include "gpe_params.svh"
package gpe_pkg;
   typedef logic [31:0] gpe_word_t;
   typedef logic [9:0] gpe_addr_t;
   typedef enum logic [1:0] {
      GPE_MODE_CHANGE = 2'h0,
      GPE_MODE_RISE = 2'h1,
      GPE_MODE_FALL = 2'h2
   } gpe_mode_e;
endpackage

// File: design/gpe_port.sv
// gpe_port.sv: one 32-pin port: registers with direct/set/clear/toggle
// access, lock and key protection, glitch filter, edge detect, irq and event.
// assumes pins are asynchronous and the local bus runs on clk.
//
// The plain strobed port and the register offsets are this design's own decisions.
`include "gpe_params.svh"
module gpe_port
   import gpe_pkg::*;
(
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   // peripheral side bus
   input wire logic [9:0] pb_addr,
   input wire logic [31:0] pb_wdata,
   input wire logic pb_wr,
   input wire logic pb_rd,
   output logic [31:0] pb_rdata,
   // cpu local bus
   input wire logic [9:0] lb_addr,
   input wire logic [31:0] lb_wdata,
   input wire logic lb_wr,
   input wire logic lb_rd,
   output logic [31:0] lb_rdata,
   // pins
   input wire logic [31:0] pin_in,
   output logic [31:0] pin_out,
   output logic [31:0] pin_oe,
   output logic [31:0] pin_owner,
   output logic [31:0] periph_in,
   // requests
   output logic [3:0] irq_line,
   output logic [3:0] event_line,
   output logic access_error_flag
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // apply one access kind to a word; direct replaces the word, for set/clear/toggle ones act, zeros leave bits
   function automatic gpe_word_t acc_apply(input gpe_word_t cur, input gpe_word_t wd,
                                           input logic [1:0] kind);
      gpe_word_t r;
      r = cur;
      case (kind)
         `GPE_ACC_DIRECT: r = wd;
         `GPE_ACC_SET: r = cur | wd;
         `GPE_ACC_CLEAR: r = cur & ~wd;
         `GPE_ACC_TOGGLE: r = cur ^ wd;
         default: r = cur;
      endcase
      return r;
   endfunction

   function automatic logic hits(input gpe_addr_t a, input gpe_addr_t base);
      return a[9:4] == base[9:4];
   endfunction

   // OR per group of eight
   function automatic logic [3:0] group_or(input gpe_word_t v);
      logic [3:0] g;
      g = 4'h0;
      for (int i = 0; i < 4; i++) begin
         g[i] = |v[i*8 +: 8];
      end
      return g;
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   gpe_word_t owner_q, drive_q, outval_q, irqen_q, mode_lo_q, mode_hi_q;
   gpe_word_t glitch_q, flag_q, even_q, lock_q;
   logic unlock_q;
   logic [9:0] unlock_ofs_q;
   logic access_error_q;
   logic [1:0] pb_kind;
   gpe_word_t pb_wmask;
   logic pb_prot_ok;
   logic pb_lock_wr;
   logic pb_protected;

   assign pb_kind = pb_addr[3:2];
   // locked bit positions take no peripheral bus write
   assign pb_wmask = `GPE_PIN_MASK & ~lock_q;
   // clearing lock bits (direct, clear, toggle) is key protected
   assign pb_lock_wr = pb_wr && hits(pb_addr, `GPE_OFF_LOCK);
   assign pb_protected = pb_lock_wr && (pb_kind != `GPE_ACC_SET);
   assign pb_prot_ok = unlock_q && (unlock_ofs_q == {pb_addr[9:4], 4'h0});

   // merge a bus write into a lockable register
   function automatic gpe_word_t pb_merge(input gpe_word_t cur, input gpe_word_t wd,
                                          input logic [1:0] kind, input gpe_word_t m);
      gpe_word_t n;
      n = acc_apply(cur, wd, kind);
      return (n & m) | (cur & ~m);
   endfunction

   // key unlock and access error
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         unlock_q <= 1'b0;
         unlock_ofs_q <= 10'h000;
         access_error_q <= 1'b0;
      end else if (clk_en && pb_wr) begin
         if (pb_addr == `GPE_OFF_UNLOCK &&
             pb_wdata[31:`GPE_KEY_LSB] == `GPE_UNLOCK_KEY) begin
            unlock_q <= 1'b1;
            unlock_ofs_q <= pb_wdata[`GPE_OFS_W-1:0];
         end else begin
            unlock_q <= 1'b0;
         end
         if (pb_protected && !pb_prot_ok) begin
            access_error_q <= 1'b1;
         end else if (pb_addr == `GPE_OFF_ASR) begin
            access_error_q <= access_error_q & pb_wdata[0];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_q <= `GPE_RST_WORD;
      end else if (clk_en && pb_lock_wr && (!pb_protected || pb_prot_ok)) begin
         lock_q <= acc_apply(lock_q, pb_wdata, pb_kind);
      end
   end

   // configuration registers on the peripheral bus
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         owner_q <= `GPE_RST_OWNER;
         irqen_q <= `GPE_RST_WORD;
         mode_lo_q <= `GPE_RST_WORD;
         mode_hi_q <= `GPE_RST_WORD;
         glitch_q <= `GPE_RST_WORD;
         even_q <= `GPE_RST_WORD;
      end else if (clk_en && pb_wr) begin
         if (hits(pb_addr, `GPE_OFF_OWNER))
            owner_q <= pb_merge(owner_q, pb_wdata, pb_kind, pb_wmask);
         if (hits(pb_addr, `GPE_OFF_IRQEN))
            irqen_q <= pb_merge(irqen_q, pb_wdata, pb_kind, pb_wmask);
         if (hits(pb_addr, `GPE_OFF_MODE_LO))
            mode_lo_q <= pb_merge(mode_lo_q, pb_wdata, pb_kind, pb_wmask);
         if (hits(pb_addr, `GPE_OFF_MODE_HI))
            mode_hi_q <= pb_merge(mode_hi_q, pb_wdata, pb_kind, pb_wmask);
         if (hits(pb_addr, `GPE_OFF_GLITCH))
            glitch_q <= pb_merge(glitch_q, pb_wdata, pb_kind, pb_wmask);
         if (hits(pb_addr, `GPE_OFF_EVEN))
            even_q <= pb_merge(even_q, pb_wdata, pb_kind, pb_wmask);
      end
   end

   // output registers: local bus wins a same-cycle clash, lock applied to peripheral bus writes only
   logic lb_drive_hit, lb_outval_hit;
   assign lb_drive_hit = lb_wr && hits(lb_addr, `GPE_OFF_DRIVE);
   assign lb_outval_hit = lb_wr && hits(lb_addr, `GPE_OFF_OUTVAL);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drive_q <= `GPE_RST_WORD;
         outval_q <= `GPE_RST_WORD;
      end else if (clk_en) begin
         if (lb_drive_hit)
            drive_q <= acc_apply(drive_q, lb_wdata, lb_addr[3:2]);
         else if (pb_wr && hits(pb_addr, `GPE_OFF_DRIVE))
            drive_q <= pb_merge(drive_q, pb_wdata, pb_kind, pb_wmask);
         if (lb_outval_hit)
            outval_q <= acc_apply(outval_q, lb_wdata, lb_addr[3:2]);
         else if (pb_wr && hits(pb_addr, `GPE_OFF_OUTVAL))
            outval_q <= pb_merge(outval_q, pb_wdata, pb_kind, pb_wmask);
      end
   end

   // ----------------------------------------------------------------
   // input path
   // ----------------------------------------------------------------
   gpe_word_t sync1_q, sync2_q, filt_q, filt_prev_q, prev_q, level_q;
   gpe_word_t sample, rise, fall, cond, flag_set;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_q <= `GPE_RST_WORD;
         sync2_q <= `GPE_RST_WORD;
      end else if (clk_en) begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   // filter: output moves only after two equal samples in a row
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         filt_prev_q <= `GPE_RST_WORD;
         filt_q <= `GPE_RST_WORD;
      end else if (clk_en) begin
         filt_prev_q <= sync2_q;
         for (int i = 0; i < 32; i++) begin
            if (sync2_q[i] == filt_prev_q[i])
               filt_q[i] <= sync2_q[i];
         end
      end
   end

   // raw readback of the synchronised pins, unfiltered
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         level_q <= `GPE_RST_WORD;
      end else if (clk_en) begin
         level_q <= sync2_q;
      end
   end
   assign periph_in = sync2_q;

   // per-pin select adds two cycles when filtered
   assign sample = (filt_q & glitch_q) | (sync2_q & ~glitch_q);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_q <= `GPE_RST_WORD;
      end else if (clk_en) begin
         prev_q <= sample;
      end
   end

   // edge compare, independent of pin owner
   assign rise = sample & ~prev_q;
   assign fall = ~sample & prev_q;
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         case ({mode_hi_q[i], mode_lo_q[i]})
            GPE_MODE_RISE: cond[i] = rise[i];
            GPE_MODE_FALL: cond[i] = fall[i];
            default: cond[i] = rise[i] | fall[i];
         endcase
      end
   end
   assign flag_set = cond & irqen_q;

   // flags: set beats a same-cycle zero write; frozen with clk_en low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag_q <= `GPE_RST_WORD;
      end else if (clk_en) begin
         if (pb_wr && pb_addr == `GPE_OFF_FLAG)
            flag_q <= (flag_q & (pb_wdata | lock_q)) | flag_set;
         else if (pb_wr && pb_addr == `GPE_OFF_FLAG + 10'h008)
            flag_q <= (flag_q & ~(pb_wdata & ~lock_q)) | flag_set;
         else
            flag_q <= flag_q | flag_set;
      end
   end

   // event pulses reuse the mode and filter, not the irq enable
   gpe_word_t event_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         event_q <= `GPE_RST_WORD;
      end else if (clk_en) begin
         event_q <= cond & even_q;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign irq_line = group_or(flag_q & irqen_q);
   assign event_line = group_or(event_q);
   assign pin_out = outval_q;
   assign pin_oe = drive_q & owner_q;
   assign pin_owner = owner_q;
   assign access_error_flag = access_error_q;

   // read mux; write-only locations and holes read zero
   function automatic gpe_word_t read_word(input gpe_addr_t a);
      gpe_word_t r;
      r = `GPE_RST_WORD;
      if (a[3:2] == 2'h0) begin
         case (a)
            `GPE_OFF_OWNER: r = owner_q;
            `GPE_OFF_DRIVE: r = drive_q;
            `GPE_OFF_OUTVAL: r = outval_q;
            `GPE_OFF_LEVEL: r = level_q;
            `GPE_OFF_IRQEN: r = irqen_q;
            `GPE_OFF_MODE_LO: r = mode_lo_q;
            `GPE_OFF_MODE_HI: r = mode_hi_q;
            `GPE_OFF_GLITCH: r = glitch_q;
            `GPE_OFF_FLAG: r = flag_q;
            `GPE_OFF_EVEN: r = even_q;
            `GPE_OFF_LOCK: r = lock_q;
            default: r = `GPE_RST_WORD;
         endcase
      end else if (a == `GPE_OFF_ASR) begin
         r = {31'h0, access_error_q};
      end
      return r;
   endfunction

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pb_rdata <= `GPE_RST_WORD;
         lb_rdata <= `GPE_RST_WORD;
      end else if (clk_en) begin
         pb_rdata <= pb_rd ? read_word(pb_addr) : `GPE_RST_WORD;
         // local bus maps only the output value and drive enable
         if (lb_rd && (lb_addr == `GPE_OFF_DRIVE || lb_addr == `GPE_OFF_OUTVAL))
            lb_rdata <= read_word(lb_addr);
         else
            lb_rdata <= `GPE_RST_WORD;
      end
   end

endmodule

// File: tb/gpe_port_assertions.sv
// gpe_port_assertions.sv: port-level checker for gpe_port, bound below.
// assumes one clock, rst async high, pins steady low through reset.
module gpe_port_chk (
   // clock and buses
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [9:0] pb_addr,
   input wire logic pb_wr,
   input wire logic pb_rd,
   input wire logic [31:0] pb_rdata,
   input wire logic [9:0] lb_addr,
   input wire logic [31:0] lb_wdata,
   input wire logic lb_wr,
   input wire logic lb_rd,
   input wire logic [31:0] lb_rdata,
   // pins and requests
   input wire logic [31:0] pin_in,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_owner,
   input wire logic [31:0] periph_in,
   input wire logic [3:0] irq_line,
   input wire logic [3:0] event_line,
   input wire logic access_error_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ----
   // assertions
   // ----
   chk_stopped_clock: assert property (!clk_en |=> $stable(irq_line) && $stable(event_line))
      else $error("request moved with clock stopped");
   chk_raw_periph: assert property ($past(clk_en) && $past(clk_en, 2) |-> periph_in == $past(pin_in, 2))
      else $error("peripheral input not raw pin");
   chk_irq_cause: assert property ($rose(irq_line[0]) |->
      $past(periph_in[7:0]) != $past(periph_in[7:0], 2) || $past(periph_in[7:0], 3) != $past(periph_in[7:0], 4))
      else $error("irq without pin edge");
   chk_event_cause: assert property (event_line[0] |->
      $past(periph_in[7:0]) != $past(periph_in[7:0], 2) || $past(periph_in[7:0], 3) != $past(periph_in[7:0], 4))
      else $error("event without pin edge");
   chk_lb_readback: assert property ($past(lb_rd) && $past(lb_addr) == 10'h050 && $past(clk_en) |-> lb_rdata == $past(pin_out))
      else $error("local read of output value wrong");
   chk_pb_owner_read: assert property ($past(pb_rd) && $past(pb_addr) == 10'h000 && $past(clk_en) |-> pb_rdata == $past(pin_owner))
      else $error("owner read wrong");
   chk_lb_direct: assert property ($past(lb_wr) && $past(lb_addr) == 10'h050 && $past(clk_en) |-> pin_out == $past(lb_wdata))
      else $error("local direct write lost");
   chk_lb_set: assert property ($past(lb_wr) && $past(lb_addr) == 10'h054 && $past(clk_en) |-> pin_out == ($past(pin_out) | $past(lb_wdata)))
      else $error("local set write wrong");
   chk_error_cause: assert property ($rose(access_error_flag) |-> $past(pb_wr) && $past(pb_addr[9:4]) == 6'h1A)
      else $error("access error without lock write");
   chk_unmapped_zero: assert property ($past(pb_rd) && $past(pb_addr) == 10'h3FC && $past(clk_en) |-> pb_rdata == 32'h0)
      else $error("unmapped read not zero");
   cover property ($rose(irq_line[0]));
   cover property (event_line[3]);
   cover property ($rose(access_error_flag));
endmodule

bind gpe_port gpe_port_chk chk_u (.clk, .rst, .clk_en, .pb_addr, .pb_wr, .pb_rd, .pb_rdata,
   .lb_addr, .lb_wdata, .lb_wr, .lb_rd, .lb_rdata, .pin_in, .pin_out, .pin_owner,
   .periph_in, .irq_line, .event_line, .access_error_flag);

// File: tb/gpe_cpu_model.sv
// gpe_cpu_model.sv: cpu side of the local bus for gpe_port.
// assumes the bench calls one task at a time, on the port clock.
module gpe_cpu_model (
   // clock
   input wire logic clk,
   // local bus
   output logic [9:0] lb_addr,
   output logic [31:0] lb_wdata,
   output logic lb_wr,
   output logic lb_rd,
   input wire logic [31:0] lb_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      lb_addr = 10'h0;
      lb_wdata = 32'h0;
      lb_wr = 1'b0;
      lb_rd = 1'b0;
   end
   // same clock as the port, so nothing is lost
   // no lock check on this side
   task lb_write(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk);
      lb_addr <= a;
      lb_wdata <= d;
      lb_wr <= 1'b1;
      @(posedge clk);
      lb_wr <= 1'b0;
      lb_wdata <= ~d;
   endtask
   task lb_read(input logic [9:0] a, output logic [31:0] d);
      @(posedge clk);
      lb_addr <= a;
      lb_rd <= 1'b1;
      @(posedge clk);
      lb_rd <= 1'b0;
      #1;
      d = lb_rdata;
   endtask
endmodule

// File: tb/gpe_port_tb.sv
// gpe_port_tb.sv: self-checking bench for one gpio port.
// assumes gpe_pkg compiled and the checker bound in.
module gpe_port_tb;
   import gpe_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic pb_wr = 1'b0, pb_rd = 1'b0, lb_wr, lb_rd, access_error_flag;
   logic [9:0] pb_addr = 10'h0, lb_addr;
   logic [31:0] pb_wdata = 32'h0, pin_in = 32'h0, pb_rdata, lb_wdata, lb_rdata;
   logic [31:0] pin_out, pin_oe, pin_owner, periph_in, rd;
   logic [3:0] irq_line, event_line;
   int bad_count = 0, check_count = 0, cyc = 0, n, c;
   int ev_cnt [4] = '{0, 0, 0, 0};

   gpe_port dut_u (.clk, .rst, .clk_en, .pb_addr, .pb_wdata, .pb_wr, .pb_rd, .pb_rdata,
      .lb_addr, .lb_wdata, .lb_wr, .lb_rd, .lb_rdata, .pin_in, .pin_out, .pin_oe,
      .pin_owner, .periph_in, .irq_line, .event_line, .access_error_flag);
   gpe_cpu_model cpu_u (.clk, .lb_addr, .lb_wdata, .lb_wr, .lb_rd, .lb_rdata);

   always #5 clk = ~clk;
   // event pulses last one cycle, so each is counted once
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) if (event_line[i] === 1'b1) ev_cnt[i]++;
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         end_of_test;
      end
   end
   // ----
   // tasks
   // ----
   task end_of_test;
      if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task pbw(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk);
      pb_addr <= a;
      pb_wdata <= d;
      pb_wr <= 1'b1;
      @(posedge clk);
      pb_wr <= 1'b0;
      #1;
   endtask
   task chkr(input logic [9:0] a, input logic [31:0] e);
      @(posedge clk);
      pb_addr <= a;
      pb_rd <= 1'b1;
      @(posedge clk);
      pb_rd <= 1'b0;
      #1;
      chk($sformatf("register %h", a), e, pb_rdata);
   endtask
   task cyc_wait(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task pin_set(input int p, input logic v);
      @(posedge clk);
      pin_in[p] <= v;
   endtask
   task hit(input int p, input logic v, input logic e);
      pin_set(p, v);
      cyc_wait(6);
      chkr(10'h0D0, e ? 32'h1 << p : 32'h0);
      chk("irq line", e ? 32'h1 << (p / 8) : 32'h0, {28'h0, irq_line});
      pbw(10'h0D0, 32'h0);
      cyc_wait(1);
      chk("irq cleared", 32'h0, {28'h0, irq_line});
   endtask
   task pulse(input int w, input logic [31:0] e);
      pin_set(2, 1'b1);
      repeat (w - 1) @(posedge clk);
      pin_set(2, 1'b0);
      cyc_wait(10);
      chkr(10'h0D0, e);
      pbw(10'h0D0, 32'h0);
   endtask
   task lat(input int e);
      pin_set(2, !pin_in[2]);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (irq_line[0] !== 1'b1 && n < 12);
      chk("irq latency", e, n);
      pbw(10'h0D0, 32'h0);
   endtask
   // ----
   // sequence
   // ----
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      chkr(10'h000, 32'hFFFF_FFFF);
      chkr(10'h090, 32'h0);
      pbw(10'h090, 32'h0000_00F0);
      pbw(10'h094, 32'h0000_000F);
      pbw(10'h098, 32'h0000_0003);
      pbw(10'h09C, 32'h0000_0101);
      chkr(10'h090, 32'h0000_01FD);
      pbw(10'h3FC, 32'hFFFF_FFFF);
      chkr(10'h3FC, 32'h0);
      pbw(10'h090, 32'h0000_0005);
      for (int m = 0; m < 3; m++) begin
         pbw(10'h0A0, {31'h0, m[0]});
         pbw(10'h0B0, {31'h0, m[1]});
         for (int v = 1; v >= 0; v--) begin
            hit(0, v[0], m == 0 || (m == 1 && v == 1) || (m == 2 && v == 0));
         end
      end
      pulse(1, 32'h4);
      pbw(10'h0C4, 32'h4);
      pulse(1, 32'h0);
      pulse(2, 32'h4);
      lat(5);
      chkr(10'h060, 32'h4);
      pbw(10'h0C8, 32'h4);
      lat(3);
      // stopped clock: pin edge must wait for the clock
      pbw(10'h094, 32'h8);
      @(posedge clk);
      clk_en <= 1'b0;
      pin_set(3, 1'b1);
      cyc_wait(8);
      chk("irq stopped", 32'h0, {28'h0, irq_line});
      @(posedge clk);
      clk_en <= 1'b1;
      cyc_wait(6);
      chk("irq resumed", 32'h1, {28'h0, irq_line});
      pbw(10'h0D0, 32'h0);
      pbw(10'h090, 32'h0);
      pbw(10'h114, 32'h2);
      c = ev_cnt[0];
      hit(1, 1'b1, 1'b0);
      chk("event only", c + 1, ev_cnt[0]);
      for (int g = 0; g < 4; g++) begin
         pbw(10'h008, 32'h1 << (8 * g + 5));
         pbw(10'h094, 32'h1 << (8 * g + 5));
         pbw(10'h114, 32'h1 << (8 * g + 5));
         c = ev_cnt[g];
         hit(8 * g + 5, 1'b1, 1'b1);
         chk("event group", c + 1, ev_cnt[g]);
         pbw(10'h098, 32'h1 << (8 * g + 5));
      end
      pbw(10'h1A4, 32'h10);
      pbw(10'h090, 32'h30);
      chkr(10'h090, 32'h20);
      cpu_u.lb_write(10'h040, 32'h10);
      pbw(10'h048, 32'h10);
      chkr(10'h040, 32'h10);
      chk("output enable", 32'h10, pin_oe);
      cpu_u.lb_write(10'h050, 32'hA5);
      cpu_u.lb_write(10'h054, 32'h100);
      cpu_u.lb_read(10'h050, rd);
      chk("local output value", 32'h1A5, rd);
      pbw(10'h1A8, 32'h10);
      chk("access error", 32'h1, {31'h0, access_error_flag});
      chkr(10'h1A0, 32'h10);
      pbw(10'h1E4, 32'h0);
      pbw(10'h1E0, 32'hAA00_01A0);
      pbw(10'h094, 32'h0);
      pbw(10'h1A8, 32'h10);
      chk("stale unlock", 32'h1, {31'h0, access_error_flag});
      pbw(10'h1E4, 32'h0);
      pbw(10'h1E0, 32'hAA00_01A0);
      pbw(10'h1A8, 32'h10);
      chkr(10'h1A0, 32'h0);
      chk("no access error", 32'h0, {31'h0, access_error_flag});
      end_of_test;
   end
endmodule
